// ---- hw/ddc_pkg.sv ----
// Constants shared by the dual converter configuration register bank.
// Assumes one 50 MHz clock and byte-wide registers on a 5-bit address.
// Operation
// - Register 0Ah bits 7:6 hold channel A coarse gain bits 1:0.
// - Register 0Ah bits 5:0 hold channel A fine gain.
// - Register 0Bh bits 7:6 hold channel A coarse gain bits 3:2.
// - Register 0Bh bits 5:0 hold channel A offset bits 10:5.
// - Register 09h bits 5:1 hold channel A offset bits 4:0.
// - Register 0Ch bit 7 set powers channel B off.
// - Register 0Ch bit 6 set puts channel B to sleep.
// - Register 0Ch bits 5:1 hold channel B offset bits 4:0.
// - Register 0Dh bits 7:6 hold channel B coarse gain bits 1:0.
// - Register 0Dh bits 5:0 hold channel B fine gain.
// - Register 0Eh bits 7:6 hold channel B coarse gain bits 3:2.
// - Register 0Eh bits 5:0 hold channel B offset bits 10:5.
// - Register 0Fh bit 1 set attenuates oscillator output by 3 dB.
// - Register 0Fh bit 0 set enables the noise shaper.
// - Register 10h bit 7 selects sync reference divide by 8, else 4.
// - Register 10h bit 6 set enables sync selection.
// - Register 1Ah holds auxiliary A code bits 9:2.
// - Register 1Bh bits 1:0 hold auxiliary A code bits 1:0.
// - Register 1Bh bit 7 set powers auxiliary A off.
// - Register 1Ch holds auxiliary B code bits 9:2.
// - Register 1Dh bits 1:0 hold auxiliary B low code; bit 7 powers B off.
package ddc_pkg;
  localparam int ADDR_W = 5;
  localparam int DATA_W = 8;
  localparam int NREG = 12;
  localparam int GAIN_C_W = 4;
  localparam int GAIN_F_W = 6;
  localparam int OFFS_W = 11;
  localparam int AUX_W = 10;
  localparam logic [ADDR_W-1:0] REG_ADDR [NREG] = '{5'h09, 5'h0a, 5'h0b, 5'h0c,
    5'h0d, 5'h0e, 5'h0f, 5'h10, 5'h1a, 5'h1b, 5'h1c, 5'h1d};
  localparam logic [DATA_W-1:0] REG_WMASK [NREG] = '{8'hfe, 8'hff, 8'hff, 8'hfe,
    8'hff, 8'hff, 8'h03, 8'hc0, 8'hff, 8'h83, 8'hff, 8'h83};
  localparam logic [DATA_W-1:0] REG_RST [NREG] = '{8'h00, 8'h00, 8'h00, 8'h00,
    8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00};
  localparam int IX_A_CFG1 = 0;
  localparam int IX_A_GLO = 1;
  localparam int IX_A_GHI = 2;
  localparam int IX_B_CFG1 = 3;
  localparam int IX_B_GLO = 4;
  localparam int IX_B_GHI = 5;
  localparam int IX_OPTS = 6;
  localparam int IX_SYNC = 7;
  localparam int IX_AUXA_HI = 8;
  localparam int IX_AUXA_LO = 9;
  localparam int IX_AUXB_HI = 10;
  localparam int IX_AUXB_LO = 11;
  localparam int PD_BIT = 7;
  localparam int SLEEP_BIT = 6;
  localparam int OFFLO_MSB = 5;
  localparam int OFFLO_LSB = 1;
  localparam int COARSE_MSB = 7;
  localparam int COARSE_LSB = 6;
  localparam int LOW6_MSB = 5;
  localparam int OSC_ATT_BIT = 1;
  localparam int NSHAPE_BIT = 0;
  localparam int SYNC_DIV_BIT = 7;
  localparam int SYNC_SEL_BIT = 6;
  localparam int AUXLO_MSB = 1;
  localparam int CMD_RD_BIT = 7;
  localparam logic [2:0] LAST_BIT = 3'h7;
  typedef enum logic [1:0] {
    DDC_IDLE = 2'b00,
    DDC_CMD = 2'b01,
    DDC_DATA = 2'b11,
    DDC_DONE = 2'b10
  } ddc_spi_state_t;
endpackage

// ---- hw/ddc_cfg_byte.sv ----
// One configuration byte with a mask of writable bits.
// Assumes a one-cycle write strobe from the serial port decoder.
`timescale 1ns/1ps
module ddc_cfg_byte #(
  parameter logic [7:0] WMASK = 8'hff,
  parameter logic [7:0] RST = 8'h00
) (
  input wire logic i_ref_clk,
  input wire logic i_rst,
  input wire logic i_wr_en,
  input wire logic [7:0] i_wr_data,
  output logic [7:0] o_value
);
  logic [7:0] value_reg;
  logic [7:0] value_next;

  always_comb
  begin
    value_next = value_reg;
    if (i_wr_en)
    begin
      value_next = (value_reg & ~WMASK) | (i_wr_data & WMASK);
    end
  end

  always_ff @(posedge i_ref_clk)
  begin
    if (i_rst)
    begin
      value_reg <= RST & WMASK;
    end
    else
    begin
      value_reg <= value_next;
    end
  end

  assign o_value = value_reg;
endmodule // ddc_cfg_byte

// ---- hw/ddc_spi_port.sv ----
// Serial control port: one command byte, then one data byte per frame.
// Assumes pins synchronous to the clock, each clock phase at least 3 cycles.
`timescale 1ns/1ps
module ddc_spi_port
  import ddc_pkg::*;
(
  input wire logic i_ref_clk,
  input wire logic i_rst,
  input wire logic i_cs_n,
  input wire logic i_sclk,
  input wire logic i_sdi,
  input wire logic i_rd_vld,
  input wire logic [DATA_W-1:0] i_rd_data,
  output logic o_sdo,
  output logic o_sdo_oe,
  output logic o_rd_req,
  output logic o_wr_req,
  output logic [ADDR_W-1:0] o_addr,
  output logic [DATA_W-1:0] o_wr_data
);
  ddc_spi_state_t st_reg, st_next;
  logic sclk_reg, sclk_next;
  logic [2:0] cnt_reg, cnt_next;
  logic [DATA_W-1:0] sh_reg, sh_next;
  logic [DATA_W-1:0] tx_reg, tx_next;
  logic rd_reg, rd_next;
  logic [ADDR_W-1:0] addr_reg, addr_next;
  logic [DATA_W-1:0] wd_reg, wd_next;
  logic sdo_reg, sdo_next;
  logic oe_reg, oe_next;
  logic rdq_reg, rdq_next;
  logic wrq_reg, wrq_next;
  logic rise;
  logic fall;

  assign rise = i_sclk & ~sclk_reg;
  assign fall = ~i_sclk & sclk_reg;

  always_comb
  begin
    st_next = st_reg;
    sclk_next = i_sclk;
    cnt_next = cnt_reg;
    sh_next = sh_reg;
    tx_next = tx_reg;
    rd_next = rd_reg;
    addr_next = addr_reg;
    wd_next = wd_reg;
    sdo_next = sdo_reg;
    oe_next = oe_reg;
    rdq_next = 1'b0;
    wrq_next = 1'b0;
    if (i_cs_n)
    begin
      st_next = DDC_IDLE;
      cnt_next = '0;
      oe_next = 1'b0;
      sdo_next = 1'b0;
    end
    else
    begin
      if (i_rd_vld)
      begin
        tx_next = i_rd_data;
      end
      case (st_reg)
        DDC_IDLE, DDC_CMD:
        begin
          st_next = DDC_CMD;
          if (rise)
          begin
            sh_next = {sh_reg[DATA_W-2:0], i_sdi};
            cnt_next = cnt_reg + 3'h1;
            if (cnt_reg == LAST_BIT)
            begin
              st_next = DDC_DATA;
              rd_next = sh_reg[CMD_RD_BIT-1];
              addr_next = {sh_reg[ADDR_W-2:0], i_sdi};
              rdq_next = sh_reg[CMD_RD_BIT-1];
            end
          end
        end
        DDC_DATA:
        begin
          if (rise)
          begin
            sh_next = {sh_reg[DATA_W-2:0], i_sdi};
            cnt_next = cnt_reg + 3'h1;
            if (cnt_reg == LAST_BIT)
            begin
              st_next = DDC_DONE;
              wrq_next = ~rd_reg;
              wd_next = {sh_reg[DATA_W-2:0], i_sdi};
            end
          end
          if (fall && rd_reg && !i_rd_vld)
          begin
            sdo_next = tx_reg[DATA_W-1];
            tx_next = {tx_reg[DATA_W-2:0], 1'b0};
            oe_next = 1'b1;
          end
        end
        DDC_DONE:
        begin
          st_next = DDC_DONE;
        end
        default:
        begin
          st_next = DDC_IDLE;
        end
      endcase
    end
  end

  always_ff @(posedge i_ref_clk)
  begin
    if (i_rst)
    begin
      st_reg <= DDC_IDLE;
      sclk_reg <= 1'b0;
      cnt_reg <= '0;
      sh_reg <= '0;
      tx_reg <= '0;
      rd_reg <= 1'b0;
      addr_reg <= '0;
      wd_reg <= '0;
      sdo_reg <= 1'b0;
      oe_reg <= 1'b0;
      rdq_reg <= 1'b0;
      wrq_reg <= 1'b0;
    end
    else
    begin
      st_reg <= st_next;
      sclk_reg <= sclk_next;
      cnt_reg <= cnt_next;
      sh_reg <= sh_next;
      tx_reg <= tx_next;
      rd_reg <= rd_next;
      addr_reg <= addr_next;
      wd_reg <= wd_next;
      sdo_reg <= sdo_next;
      oe_reg <= oe_next;
      rdq_reg <= rdq_next;
      wrq_reg <= wrq_next;
    end
  end

  assign o_sdo = sdo_reg;
  assign o_sdo_oe = oe_reg;
  assign o_rd_req = rdq_reg;
  assign o_wr_req = wrq_reg;
  assign o_addr = addr_reg;
  assign o_wr_data = wd_reg;
endmodule // ddc_spi_port

// ---- hw/ddc_cfg_regs.sv ----
// Configuration register bank of both converter channels.
// Holds gain, offset, power, oscillator, sync and auxiliary settings.
// Assumes serial port pins synchronous to the 50 MHz reference clock.
`timescale 1ns/1ps
module ddc_cfg_regs (
  input wire logic i_ref_clk,
  input wire logic i_rst,
  input wire logic i_spi_cs_n,
  input wire logic i_spi_sclk,
  input wire logic i_spi_sdi,
  output logic o_spi_sdo,
  output logic o_spi_sdo_oe,
  output logic [ddc_pkg::GAIN_C_W-1:0] o_chan_a_gain_coarse,
  output logic [ddc_pkg::GAIN_F_W-1:0] o_chan_a_gain_fine,
  output logic [ddc_pkg::OFFS_W-1:0] o_chan_a_offset,
  output logic o_chan_a_power_off,
  output logic o_chan_a_sleep,
  output logic [ddc_pkg::GAIN_C_W-1:0] o_chan_b_gain_coarse,
  output logic [ddc_pkg::GAIN_F_W-1:0] o_chan_b_gain_fine,
  output logic [ddc_pkg::OFFS_W-1:0] o_chan_b_offset,
  output logic o_chan_b_power_off,
  output logic o_chan_b_sleep,
  output logic o_osc_gain_attenuate,
  output logic o_noise_shaping_enable,
  output logic o_sync_ref_div8,
  output logic o_sync_select_enable,
  output logic [ddc_pkg::AUX_W-1:0] o_aux_conv_a_code,
  output logic o_aux_conv_a_power_off,
  output logic [ddc_pkg::AUX_W-1:0] o_aux_conv_b_code,
  output logic o_aux_conv_b_power_off
);
  import ddc_pkg::*;

  logic rd_req;
  logic wr_req;
  logic [ADDR_W-1:0] addr;
  logic [DATA_W-1:0] wr_data;
  logic [DATA_W-1:0] regs [NREG];
  logic [DATA_W-1:0] rd_data_reg, rd_data_next;
  logic rd_vld_reg, rd_vld_next;

  // ---------------------------------------------------------------
  // Serial control port
  // ---------------------------------------------------------------
  ddc_spi_port u_port (
    .i_ref_clk(i_ref_clk),
    .i_rst(i_rst),
    .i_cs_n(i_spi_cs_n),
    .i_sclk(i_spi_sclk),
    .i_sdi(i_spi_sdi),
    .i_rd_vld(rd_vld_reg),
    .i_rd_data(rd_data_reg),
    .o_sdo(o_spi_sdo),
    .o_sdo_oe(o_spi_sdo_oe),
    .o_rd_req(rd_req),
    .o_wr_req(wr_req),
    .o_addr(addr),
    .o_wr_data(wr_data)
  );

  // ---------------------------------------------------------------
  // Register bytes
  // ---------------------------------------------------------------
  for (genvar g = 0; g < NREG; g++)
  begin : g_reg
    ddc_cfg_byte #(
      .WMASK(REG_WMASK[g]),
      .RST(REG_RST[g])
    ) u_byte (
      .i_ref_clk(i_ref_clk),
      .i_rst(i_rst),
      .i_wr_en(wr_req && (addr == REG_ADDR[g])),
      .i_wr_data(wr_data),
      .o_value(regs[g])
    );
  end

  // ---------------------------------------------------------------
  // Read data, zero for unmapped addresses
  // ---------------------------------------------------------------
  // unmapped reads zero
  always_comb
  begin
    rd_data_next = rd_data_reg;
    rd_vld_next = rd_req;
    if (rd_req)
    begin
      rd_data_next = '0;
      for (int k = 0; k < NREG; k++)
      begin
        if (addr == REG_ADDR[k])
        begin
          rd_data_next = regs[k];
        end
      end
    end
  end

  always_ff @(posedge i_ref_clk)
  begin
    if (i_rst)
    begin
      rd_data_reg <= '0;
      rd_vld_reg <= 1'b0;
    end
    else
    begin
      rd_data_reg <= rd_data_next;
      rd_vld_reg <= rd_vld_next;
    end
  end

  // ---------------------------------------------------------------
  // Channel A fields
  // ---------------------------------------------------------------
  // coarse gain join
  assign o_chan_a_gain_coarse = {regs[IX_A_GHI][COARSE_MSB:COARSE_LSB],
    regs[IX_A_GLO][COARSE_MSB:COARSE_LSB]};
  assign o_chan_a_gain_fine = regs[IX_A_GLO][LOW6_MSB:0];
  assign o_chan_a_offset = {regs[IX_A_GHI][LOW6_MSB:0],
    regs[IX_A_CFG1][OFFLO_MSB:OFFLO_LSB]};
  assign o_chan_a_power_off = regs[IX_A_CFG1][PD_BIT];
  assign o_chan_a_sleep = regs[IX_A_CFG1][SLEEP_BIT];

  // ---------------------------------------------------------------
  // Channel B fields
  // ---------------------------------------------------------------
  // coarse gain join
  assign o_chan_b_gain_coarse = {regs[IX_B_GHI][COARSE_MSB:COARSE_LSB],
    regs[IX_B_GLO][COARSE_MSB:COARSE_LSB]};
  assign o_chan_b_gain_fine = regs[IX_B_GLO][LOW6_MSB:0];
  assign o_chan_b_offset = {regs[IX_B_GHI][LOW6_MSB:0],
    regs[IX_B_CFG1][OFFLO_MSB:OFFLO_LSB]};
  assign o_chan_b_power_off = regs[IX_B_CFG1][PD_BIT];
  assign o_chan_b_sleep = regs[IX_B_CFG1][SLEEP_BIT];

  // ---------------------------------------------------------------
  // Shared options and sync reference
  // ---------------------------------------------------------------
  // oscillator attenuation
  assign o_osc_gain_attenuate = regs[IX_OPTS][OSC_ATT_BIT];
  assign o_noise_shaping_enable = regs[IX_OPTS][NSHAPE_BIT];
  assign o_sync_ref_div8 = regs[IX_SYNC][SYNC_DIV_BIT];
  assign o_sync_select_enable = regs[IX_SYNC][SYNC_SEL_BIT];

  // ---------------------------------------------------------------
  // Auxiliary converters
  // ---------------------------------------------------------------
  // aux A code
  assign o_aux_conv_a_code = {regs[IX_AUXA_HI], regs[IX_AUXA_LO][AUXLO_MSB:0]};
  assign o_aux_conv_a_power_off = regs[IX_AUXA_LO][PD_BIT];
  assign o_aux_conv_b_code = {regs[IX_AUXB_HI], regs[IX_AUXB_LO][AUXLO_MSB:0]};
  assign o_aux_conv_b_power_off = regs[IX_AUXB_LO][PD_BIT];

  // ---------------------------------------------------------------
  // Assertions
  // ---------------------------------------------------------------
  default clocking cb @(posedge i_ref_clk); endclocking
  default disable iff (i_rst);

  a_a_gain_low: assert property (
    wr_req && addr == REG_ADDR[IX_A_GLO] |=>
      o_chan_a_gain_coarse[1:0] == $past(wr_data[7:6]) &&
      o_chan_a_gain_fine == $past(wr_data[5:0]) &&
      $stable(o_chan_a_gain_coarse[3:2]))
    else $error("channel A gain low byte not applied");

  a_a_gain_high: assert property (
    wr_req && addr == REG_ADDR[IX_A_GHI] |=>
      o_chan_a_gain_coarse[3:2] == $past(wr_data[7:6]) &&
      o_chan_a_offset[10:5] == $past(wr_data[5:0]) &&
      $stable(o_chan_a_offset[4:0]))
    else $error("channel A high byte not applied");

  a_a_offset_low: assert property (
    wr_req && addr == REG_ADDR[IX_A_CFG1] |=>
      o_chan_a_offset[4:0] == $past(wr_data[5:1]) &&
      $stable(o_chan_a_offset[10:5]))
    else $error("channel A offset low not applied");

  a_b_power_sleep: assert property (
    wr_req && addr == REG_ADDR[IX_B_CFG1] |=>
      o_chan_b_power_off == $past(wr_data[7]) &&
      o_chan_b_sleep == $past(wr_data[6]) &&
      o_chan_b_offset[4:0] == $past(wr_data[5:1]))
    else $error("channel B power, sleep or offset wrong");

  a_b_gain_low: assert property (
    wr_req && addr == REG_ADDR[IX_B_GLO] |=>
      o_chan_b_gain_coarse[1:0] == $past(wr_data[7:6]) &&
      o_chan_b_gain_fine == $past(wr_data[5:0]) &&
      $stable(o_chan_b_gain_coarse[3:2]))
    else $error("channel B gain low byte not applied");

  a_b_gain_offset: assert property (
    wr_req && addr == REG_ADDR[IX_B_GHI] |=>
      o_chan_b_gain_coarse[3:2] == $past(wr_data[7:6]) &&
      o_chan_b_offset[10:5] == $past(wr_data[5:0]) &&
      $stable(o_chan_b_offset[4:0]))
    else $error("channel B high byte not applied");

  a_osc_options: assert property (
    wr_req && addr == REG_ADDR[IX_OPTS] |=>
      o_osc_gain_attenuate == $past(wr_data[1]) &&
      o_noise_shaping_enable == $past(wr_data[0]))
    else $error("oscillator options not applied");

  a_sync_setup: assert property (
    wr_req && addr == REG_ADDR[IX_SYNC] |=>
      o_sync_ref_div8 == $past(wr_data[7]) &&
      o_sync_select_enable == $past(wr_data[6]))
    else $error("sync setup not applied");

  a_aux_a_code: assert property (
    wr_req && addr == REG_ADDR[IX_AUXA_LO] |=>
      o_aux_conv_a_code[1:0] == $past(wr_data[1:0]) &&
      o_aux_conv_a_power_off == $past(wr_data[7]) &&
      $stable(o_aux_conv_a_code[9:2]))
    else $error("aux A low byte not applied");

  a_aux_b_code: assert property (
    wr_req && addr == REG_ADDR[IX_AUXB_HI] |=>
      o_aux_conv_b_code[9:2] == $past(wr_data) &&
      $stable(o_aux_conv_b_power_off))
    else $error("aux B high byte not applied");

  a_reserved_zero: assert property (
    rd_req && addr == REG_ADDR[IX_SYNC] |=>
      rd_vld_reg && rd_data_reg[5:0] == 6'h00 &&
      rd_data_reg[7:6] == {o_sync_ref_div8, o_sync_select_enable})
    else $error("reserved sync bits not zero on read");

  a_unmapped_read: assert property (
    rd_req && addr == 5'h00 |=> rd_data_reg == 8'h00)
    else $error("unmapped read not zero");

  a_aux_a_high: assert property (
    wr_req && addr == REG_ADDR[IX_AUXA_HI] |=>
      o_aux_conv_a_code[9:2] == $past(wr_data) &&
      $stable(o_aux_conv_a_code[1:0]) && $stable(o_aux_conv_a_power_off))
    else $error("aux A high byte not applied");

  a_aux_b_low: assert property (
    wr_req && addr == REG_ADDR[IX_AUXB_LO] |=>
      o_aux_conv_b_code[1:0] == $past(wr_data[1:0]) &&
      o_aux_conv_b_power_off == $past(wr_data[7]) &&
      $stable(o_aux_conv_b_code[9:2]))
    else $error("aux B low byte not applied");

  a_opts_read: assert property (
    rd_req && addr == REG_ADDR[IX_OPTS] |=>
      rd_data_reg[7:2] == 6'h00 &&
      rd_data_reg[1:0] == {o_osc_gain_attenuate, o_noise_shaping_enable})
    else $error("option byte read back wrong");

  a_aux_lo_read: assert property (
    rd_req && addr == REG_ADDR[IX_AUXA_LO] |=>
      rd_data_reg[6:2] == 5'h00 &&
      rd_data_reg[7] == o_aux_conv_a_power_off &&
      rd_data_reg[1:0] == o_aux_conv_a_code[1:0])
    else $error("aux A low byte read back wrong");

  // channel B first byte read back
  a_b_cfg_read: assert property (
    rd_req && addr == REG_ADDR[IX_B_CFG1] |=>
      rd_data_reg[0] == 1'b0 &&
      rd_data_reg[7:1] == {o_chan_b_power_off, o_chan_b_sleep, o_chan_b_offset[4:0]})
    else $error("channel B first byte read back wrong");

  // channel A first byte read back
  a_a_cfg_read: assert property (
    rd_req && addr == REG_ADDR[IX_A_CFG1] |=>
      rd_data_reg[0] == 1'b0 &&
      rd_data_reg[7:1] == {o_chan_a_power_off, o_chan_a_sleep, o_chan_a_offset[4:0]})
    else $error("channel A first byte read back wrong");

  c_write_cfg: cover property (wr_req && addr == REG_ADDR[IX_B_CFG1]);
  c_write_aux_b: cover property (wr_req && addr == REG_ADDR[IX_AUXB_LO]);
  c_read_opts: cover property (rd_req && addr == REG_ADDR[IX_OPTS]);
  c_read_aux: cover property (rd_req && addr == REG_ADDR[IX_AUXA_LO]);
  c_sdo_drive: cover property ($rose(o_spi_sdo_oe));
endmodule // ddc_cfg_regs

// ---- sim/testbench.sv ----
// Self-checking bench for the dual converter configuration register bank.
// Assumes the bank is reached only through its serial control port pins.
`timescale 1ns/1ps
module testbench;
  import ddc_pkg::*;
  // ----------------------------------------------------------------
  // Signals and model
  // ----------------------------------------------------------------
  logic i_ref_clk;
  logic i_rst;
  logic cs_n;
  logic sclk;
  logic sdi;
  logic sdo;
  logic oe;
  logic [GAIN_C_W-1:0] a_gc, b_gc;
  logic [GAIN_F_W-1:0] a_gf, b_gf;
  logic [OFFS_W-1:0] a_off, b_off;
  logic a_pd, a_sl, b_pd, b_sl, osc_att, nshape, div8, sync_sel, xa_pd, xb_pd;
  logic [AUX_W-1:0] xa_code, xb_code;
  logic [7:0] mdl [32];
  logic [4:0] alist [12] = '{5'h09, 5'h0a, 5'h0b, 5'h0c, 5'h0d, 5'h0e, 5'h0f, 5'h10,
    5'h1a, 5'h1b, 5'h1c, 5'h1d};
  int fail_count = 0;
  int checks = 0;
  logic [31:0] lfsr_state = 32'h00017ddf;

  ddc_cfg_regs u_dut (
    .i_ref_clk(i_ref_clk), .i_rst(i_rst), .i_spi_cs_n(cs_n), .i_spi_sclk(sclk),
    .i_spi_sdi(sdi), .o_spi_sdo(sdo), .o_spi_sdo_oe(oe),
    .o_chan_a_gain_coarse(a_gc), .o_chan_a_gain_fine(a_gf), .o_chan_a_offset(a_off),
    .o_chan_a_power_off(a_pd), .o_chan_a_sleep(a_sl),
    .o_chan_b_gain_coarse(b_gc), .o_chan_b_gain_fine(b_gf), .o_chan_b_offset(b_off),
    .o_chan_b_power_off(b_pd), .o_chan_b_sleep(b_sl),
    .o_osc_gain_attenuate(osc_att), .o_noise_shaping_enable(nshape),
    .o_sync_ref_div8(div8), .o_sync_select_enable(sync_sel),
    .o_aux_conv_a_code(xa_code), .o_aux_conv_a_power_off(xa_pd),
    .o_aux_conv_b_code(xb_code), .o_aux_conv_b_power_off(xb_pd)
  );

  initial
  begin
    i_ref_clk = 1'b0;
    forever #10 i_ref_clk = ~i_ref_clk;
  end

  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  function automatic logic [7:0] rnd8();
    lfsr_state = {lfsr_state[30:0], lfsr_state[31] ^ lfsr_state[21] ^ lfsr_state[1]
      ^ lfsr_state[0]};
    return lfsr_state[7:0] ^ lfsr_state[23:16];
  endfunction

  // Writable bits of each byte; everything else reads zero.
  function automatic logic [7:0] wmask(input logic [4:0] a);
    case (a)
      5'h09, 5'h0c: return 8'hfe;
      5'h0a, 5'h0b, 5'h0d, 5'h0e, 5'h1a, 5'h1c: return 8'hff;
      5'h0f: return 8'h03;
      5'h10: return 8'hc0;
      5'h1b, 5'h1d: return 8'h83;
      default: return 8'h00;
    endcase
  endfunction

  task automatic results();
    if (fail_count == 0 && checks > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask

  task automatic tick(input int n);
    repeat (n) @(posedge i_ref_clk);
    #1;
  endtask

  task automatic cmp(input logic [15:0] got, input logic [15:0] exp, input string what);
    checks++;
    if (got !== exp)
    begin
      fail_count++;
      $display("[ERR] %0t %s got %h expected %h", $time, what, got, exp);
    end
  endtask

  // One frame; nbits below 16 aborts it by raising the select early.
  task automatic spi(input bit rd, input logic [4:0] a, input logic [7:0] wd,
    input int nbits, output logic [7:0] rdv);
    logic [15:0] fr;
    logic [7:0] ign;
    ign = rnd8();
    fr = {rd, ign[1:0], a, wd};
    rdv = 8'h00;
    cs_n = 1'b0;
    tick(2);
    for (int i = 0; i < nbits; i++)
    begin
      sclk = 1'b0;
      sdi = fr[15-i];
      tick(4);
      if (rd && i >= 8)
      begin
        rdv[15-i] = sdo;
        cmp(oe, 1, "sdo enable during read");
      end
      sclk = 1'b1;
      tick(4);
    end
    sclk = 1'b0;
    tick(4);
    cs_n = 1'b1;
    tick(3);
    cmp(oe, 0, "sdo enable after frame");
    if (!rd && nbits >= 16)
      mdl[a] = wd & wmask(a);
  endtask

  task automatic check_fields();
    // coarse gain joins upper and lower bits.
    cmp(a_gc, {mdl[5'h0b][7:6], mdl[5'h0a][7:6]}, "a coarse");
    cmp(a_gf, mdl[5'h0a][5:0], "a fine");
    cmp(a_off, {mdl[5'h0b][5:0], mdl[5'h09][5:1]}, "a offset");
    cmp({a_pd, a_sl}, mdl[5'h09][7:6], "a power sleep");
    cmp(b_pd, mdl[5'h0c][7], "b power");
    cmp(b_sl, mdl[5'h0c][6], "b sleep");
    cmp(b_off, {mdl[5'h0e][5:0], mdl[5'h0c][5:1]}, "b offset");
    cmp(b_gc, {mdl[5'h0e][7:6], mdl[5'h0d][7:6]}, "b coarse");
    cmp(b_gf, mdl[5'h0d][5:0], "b fine");
    cmp(osc_att, mdl[5'h0f][1], "osc gain");
    cmp(nshape, mdl[5'h0f][0], "noise shaper");
    cmp(div8, mdl[5'h10][7], "sync divider");
    cmp(sync_sel, mdl[5'h10][6], "sync select");
    cmp(xa_code, {mdl[5'h1a], mdl[5'h1b][1:0]}, "aux a code");
    cmp(xa_pd, mdl[5'h1b][7], "aux a power");
    cmp(xb_code, {mdl[5'h1c], mdl[5'h1d][1:0]}, "aux b code");
    cmp(xb_pd, mdl[5'h1d][7], "aux b power");
  endtask

  task automatic check_all();
    logic [7:0] rv;
    for (int k = 0; k < 12; k++)
    begin
      spi(1'b1, alist[k], rnd8(), 16, rv);
      cmp(rv, mdl[alist[k]], "register read back");
    end
    check_fields();
  endtask

  // ----------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------
  initial
  begin
    logic [7:0] rv;
    i_rst = 1'b1;
    cs_n = 1'b1;
    sclk = 1'b0;
    sdi = 1'b0;
    for (int k = 0; k < 32; k++)
      mdl[k] = 8'h00;
    repeat (12) @(posedge i_ref_clk);
    #1;
    i_rst = 1'b0;
    tick(1);
    check_all();
    // Full ones, zeros, then random bytes in every register.
    for (int r = 0; r < 4; r++)
    begin
      for (int k = 0; k < 12; k++)
      begin
        spi(1'b0, alist[k], (r == 0) ? 8'hff : (r == 1) ? 8'h00 : rnd8(), 16, rv);
        check_fields();
      end
      check_all();
    end
    // Unmapped places read zero and change nothing.
    spi(1'b0, 5'h11, 8'hff, 16, rv);
    spi(1'b0, 5'h00, 8'hff, 16, rv);
    spi(1'b1, 5'h11, 8'h00, 16, rv);
    cmp(rv, 8'h00, "unmapped read");
    spi(1'b1, 5'h00, 8'h00, 16, rv);
    cmp(rv, 8'h00, "unmapped read at zero");
    check_fields();
    // A frame cut short must not write.
    spi(1'b0, 5'h0f, ~mdl[5'h0f], 12, rv);
    spi(1'b0, 5'h1d, ~mdl[5'h1d], 15, rv);
    check_all();
    // Reset in mid-run clears every byte.
    i_rst = 1'b1;
    tick(2);
    i_rst = 1'b0;
    tick(1);
    for (int k = 0; k < 32; k++)
      mdl[k] = 8'h00;
    check_all();
    results();
  end

  initial
  begin
    repeat (100000) @(posedge i_ref_clk);
    fail_count++;
    $display("[ERR] %0t run did not finish", $time);
    results();
  end
endmodule // testbench
